// File: rtl/fsbc_pkg.sv
// Purpose: shared constants for the flash suspend/bypass command host
// Assumes: 16-bit word bus, word addressing
// Notes:   bus timing counts are in CLOCK cycles at 125 MHz
package fsbc_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    // command data words
    localparam logic [15:0] D_UNLOCK1      = 16'h00aa;
    localparam logic [15:0] D_UNLOCK2      = 16'h0055;
    localparam logic [15:0] D_BYPASS_ENTER = 16'h0020;
    localparam logic [15:0] D_SUSPEND      = 16'h00b0;
    localparam logic [15:0] D_RESUME       = 16'h0030;
    localparam logic [15:0] D_PROG_SETUP   = 16'h00a0;
    localparam logic [15:0] D_BYPASS_EXIT1 = 16'h0090;
    localparam logic [15:0] D_BYPASS_EXIT2 = 16'h0000;
    localparam logic [15:0] D_RESET        = 16'h00f0;
    // word offsets of the unlock cycles
    localparam logic [11:0] A_UNLOCK1      = 12'h555;
    localparam logic [11:0] A_UNLOCK2      = 12'h2aa;
    // write pulse shape in cycles
    localparam logic [3:0]  WE_SETUP_CYC   = 4'h2;
    localparam logic [3:0]  WE_LOW_CYC     = 4'h5;
    localparam logic [3:0]  WE_HOLD_CYC    = 4'h3;
    // accelerated program use limit per sector
    localparam logic [3:0]  ACCEL_MAX_USES = 4'ha;
    // suspend latency bounds in microseconds and cycles
    localparam int unsigned PSUSP_MAX_US   = 15;
    localparam int unsigned ESUSP_MAX_US   = 20;
    localparam int unsigned PSUSP_CYC      = PSUSP_MAX_US * CLK_MHZ;
    localparam int unsigned ESUSP_CYC      = ESUSP_MAX_US * CLK_MHZ;
    // request opcodes from the user side
    typedef enum logic [3:0] {
        FSBC_OP_ESUSPEND = 4'h0,
        FSBC_OP_ERESUME  = 4'h1,
        FSBC_OP_PSUSPEND = 4'h2,
        FSBC_OP_PRESUME  = 4'h3,
        FSBC_OP_BYP_ENT  = 4'h4,
        FSBC_OP_BYP_PROG = 4'h5,
        FSBC_OP_BYP_EXIT = 4'h6,
        FSBC_OP_RESET3   = 4'h7,
        FSBC_OP_ACC_ON   = 4'h8,
        FSBC_OP_ACC_OFF  = 4'h9
    } fsbc_op_t;
endpackage : fsbc_pkg

// File: rtl/fsbc_sync.sv
// Purpose: three-flop pin synchroniser with agreement check
// Assumes: input is asynchronous to CLOCK
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
module fsbc_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic s1_reg;   // metastable catcher, read by s2 only
    logic s2_reg;   // second stage
    logic s3_reg;   // third stage
    logic q_reg;    // filtered level
    // shift chain and agreement filter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg  <= 1'b0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                q_reg <= s3_reg;
        end
    end
    assign dout = q_reg;
endmodule : fsbc_sync

// File: rtl/fsbc_wcycle.sv
// Purpose: one asynchronous flash bus write cycle generator
// Assumes: single request held until done pulse
// Notes:   we_n low for WE_LOW_CYC, data driven across setup and hold
`timescale 1ns/1ps
module fsbc_wcycle
    import fsbc_pkg::*;
#(
    parameter int AW = 24
)
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   data,
    output logic               done,
    output logic               busy,
    output logic [AW-1:0]      a_out,
    output logic [15:0]        dq_out,
    output logic               dq_oe,
    output logic               we_n
);
    typedef enum logic [1:0] {
        FSBC_W_IDLE  = 2'b00,
        FSBC_W_SETUP = 2'b01,
        FSBC_W_LOW   = 2'b11,
        FSBC_W_HOLD  = 2'b10
    } fsbc_wst_t;
    fsbc_wst_t      st_reg;     // cycle phase
    fsbc_wst_t      st_next;
    logic [3:0]     cnt_reg;    // phase counter
    logic [AW-1:0]  a_reg;      // latched address
    logic [15:0]    d_reg;      // latched data
    logic           phase_end;  // current phase done
    assign phase_end = (cnt_reg == 4'h1);
    // phase sequencing
    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            FSBC_W_IDLE:  if (start) st_next = FSBC_W_SETUP;
            FSBC_W_SETUP: if (phase_end) st_next = FSBC_W_LOW;
            FSBC_W_LOW:   if (phase_end) st_next = FSBC_W_HOLD;
            FSBC_W_HOLD:  if (phase_end) st_next = FSBC_W_IDLE;
            default:      st_next = FSBC_W_IDLE;
        endcase
    end
    // state, counter and latches
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_reg  <= FSBC_W_IDLE;
            cnt_reg <= 4'h0;
            a_reg   <= '0;
            d_reg   <= 16'h0000;
        end
        else
        begin
            st_reg <= st_next;
            if (st_reg == FSBC_W_IDLE && start)
            begin
                a_reg   <= addr;
                d_reg   <= data;
                cnt_reg <= WE_SETUP_CYC;
            end
            else if (st_reg != st_next)
                cnt_reg <= (st_next == FSBC_W_LOW) ? WE_LOW_CYC
                                                    : WE_HOLD_CYC;
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
        end
    end
    assign done   = (st_reg == FSBC_W_HOLD) && phase_end;
    assign busy   = (st_reg != FSBC_W_IDLE);
    assign a_out  = a_reg;
    assign dq_out = d_reg;
    assign dq_oe  = busy;
    assign we_n   = (st_reg != FSBC_W_LOW);
endmodule : fsbc_wcycle

// File: rtl/fsbc_host.sv
// Purpose: host sequencer for flash suspend, resume and bypass commands
// Assumes: one request at a time, REQ held until ACK
// Notes:   address bits above the word offset select base or sector
// Function
// - erase suspend: one write of 00B0h
// - erase resume: 0030h to suspended sector
// - program suspend: one 00B0h write, any address
// - program resume: 0030h at any address
// - buffer abort recovery needs full three writes
// - at most ten accel uses per sector
// - unlock sectors before raising accel voltage
// - high voltage only during accelerated programming
// - bypass exit: 90h at sector, then 00h
// - bypass entry: AAh@555, 55h@2AA, 20h@555
`timescale 1ns/1ps
module fsbc_host
    import fsbc_pkg::*;
#(
    parameter int AW      = 24,
    parameter int SECT_W  = 8
)
(
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    input  wire logic              REQ,
    input  wire logic [3:0]        OP,
    input  wire logic [AW-1:0]     ADDR,
    input  wire logic [15:0]       WDATA,
    output logic                   ACK,
    output logic                   ERR,
    output logic                   BYPASS,
    output logic                   PSUSP,
    output logic                   ESUSP,
    input  wire logic              FLASH_BUSY_IN,
    output logic [AW-1:0]          FLASH_A,
    output logic [15:0]            FLASH_DQ_O,
    output logic                   FLASH_DQ_OE,
    output logic                   FLASH_WE_N,
    output logic                   ACCEL_HV_EN
);
    typedef enum logic [2:0] {
        FSBC_IDLE = 3'b000,
        FSBC_W0   = 3'b001,
        FSBC_W1   = 3'b011,
        FSBC_W2   = 3'b010,
        FSBC_FIN  = 3'b110
    } fsbc_st_t;
    fsbc_st_t          st_reg;        // sequencer state
    fsbc_st_t          st_next;
    logic [3:0]        op_reg;        // request being served
    logic [AW-1:0]     adr_reg;       // latched request address
    logic [15:0]       dat_reg;       // latched request data
    logic              byp_reg;       // bypass mode as host sees it
    logic              psusp_reg;     // program suspended
    logic              esusp_reg;     // erase suspended
    logic              acc_reg;       // high voltage enabled
    logic [AW-1:0]     esect_reg;     // sector address of erase suspend
    logic [1:0]        nwr;           // writes in the current op minus one
    logic [1:0]        idx_reg;       // index of current write
    logic              legal;         // request allowed now
    logic              w_start;       // launch a bus write
    logic              w_done;        // bus write finished
    logic              w_busy;        // bus write in progress
    logic [AW-1:0]     w_addr;        // address of current write
    logic [15:0]       w_data;        // data of current write
    logic              busy_s;        // synchronised device busy
    logic [3:0]        acc_use [2**SECT_W]; // accel uses per sector
    logic [SECT_W-1:0] sect;          // sector of request
    logic [AW-1:0]     base;          // request address, offset cleared

    // sector index from the upper address bits
    function automatic logic [SECT_W-1:0] sect_of(input logic [AW-1:0] a);
        sect_of = a[AW-1 -: SECT_W];
    endfunction : sect_of

    assign sect = sect_of(ADDR);
    assign base = {adr_reg[AW-1:12], 12'h000};

    // device busy pin crosses in through four flops
    fsbc_sync u_busy_sync
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .din   (FLASH_BUSY_IN),
        .dout  (busy_s)
    );

    // request legality by mode
    assign legal =
        (OP == FSBC_OP_ESUSPEND) ? !byp_reg && !esusp_reg :
        (OP == FSBC_OP_ERESUME)  ? !byp_reg && esusp_reg && !psusp_reg &&
                                   (sect_of(ADDR) ==
                                    sect_of(esect_reg)) :
        (OP == FSBC_OP_PSUSPEND) ? !byp_reg && !psusp_reg :
        (OP == FSBC_OP_PRESUME)  ? psusp_reg :
        (OP == FSBC_OP_BYP_ENT)  ? !byp_reg && !psusp_reg :
        (OP == FSBC_OP_BYP_PROG) ? byp_reg :
        (OP == FSBC_OP_BYP_EXIT) ? byp_reg && !acc_reg :
        (OP == FSBC_OP_RESET3)   ? 1'b1 :
        (OP == FSBC_OP_ACC_ON)   ? !acc_reg && !psusp_reg &&
                                   !esusp_reg &&
                                   (acc_use[sect] < ACCEL_MAX_USES) :
        (OP == FSBC_OP_ACC_OFF)  ? acc_reg && !busy_s :
        1'b0;

    // number of bus writes minus one for each operation
    assign nwr =
        (op_reg == FSBC_OP_BYP_ENT)  ? 2'd2 :
        (op_reg == FSBC_OP_RESET3)   ? 2'd2 :
        (op_reg == FSBC_OP_BYP_PROG) ? 2'd1 :
        (op_reg == FSBC_OP_BYP_EXIT) ? 2'd1 :
        2'd0;

    // address and data of each write of the current sequence
    always_comb
    begin
        w_addr = adr_reg;
        w_data = dat_reg;
        case (op_reg)
            FSBC_OP_ESUSPEND, FSBC_OP_PSUSPEND:
                w_data = D_SUSPEND;
            FSBC_OP_ERESUME:
                w_data = D_RESUME;
            FSBC_OP_PRESUME:
                w_data = D_RESUME;
            FSBC_OP_BYP_ENT, FSBC_OP_RESET3:
            begin
                w_addr = base | AW'(idx_reg == 2'd1 ? A_UNLOCK2
                                                    : A_UNLOCK1);
                w_data = (idx_reg == 2'd0) ? D_UNLOCK1 :
                         (idx_reg == 2'd1) ? D_UNLOCK2 :
                         (op_reg == FSBC_OP_BYP_ENT) ? D_BYPASS_ENTER
                                                     : D_RESET;
            end
            FSBC_OP_BYP_PROG:
            begin
                if (idx_reg == 2'd0)
                    w_data = D_PROG_SETUP;
            end
            FSBC_OP_BYP_EXIT:
                w_data = (idx_reg == 2'd0) ? D_BYPASS_EXIT1
                                           : D_BYPASS_EXIT2;
            default: ;
        endcase
    end

    // sequencer transitions
    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            FSBC_IDLE:
                if (REQ) st_next = legal ? FSBC_W0 : FSBC_FIN;
            FSBC_W0:
                st_next = (op_reg == FSBC_OP_ACC_ON ||
                           op_reg == FSBC_OP_ACC_OFF) ? FSBC_FIN
                                                      : FSBC_W1;
            FSBC_W1:
                if (w_done) st_next = (idx_reg == nwr) ? FSBC_FIN
                                                       : FSBC_W2;
            FSBC_W2:
                st_next = FSBC_W1;
            FSBC_FIN:
                if (!REQ) st_next = FSBC_IDLE;
            default:
                st_next = FSBC_IDLE;
        endcase
    end

    assign w_start = (st_reg == FSBC_W1) && !w_busy && !w_done;

    // bus write cycle engine
    fsbc_wcycle #(.AW(AW)) u_wcycle
    (
        .clk    (CLOCK),
        .rst_n  (RST_N),
        .start  (w_start),
        .addr   (w_addr),
        .data   (w_data),
        .done   (w_done),
        .busy   (w_busy),
        .a_out  (FLASH_A),
        .dq_out (FLASH_DQ_O),
        .dq_oe  (FLASH_DQ_OE),
        .we_n   (FLASH_WE_N)
    );

    // request latch, write index and error flag
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            st_reg  <= FSBC_IDLE;
            op_reg  <= 4'h0;
            adr_reg <= '0;
            dat_reg <= 16'h0000;
            idx_reg <= 2'd0;
            ERR     <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            if (st_reg == FSBC_IDLE && REQ)
            begin
                op_reg  <= OP;
                adr_reg <= ADDR;
                dat_reg <= WDATA;
                idx_reg <= 2'd0;
                ERR     <= !legal;
            end
            else if (st_reg == FSBC_W2)
                idx_reg <= idx_reg + 2'd1;
        end
    end

    // mode tracking as seen from the host
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            byp_reg   <= 1'b0;
            psusp_reg <= 1'b0;
            esusp_reg <= 1'b0;
            acc_reg   <= 1'b0;
            esect_reg <= '0;
        end
        else if (st_reg inside {FSBC_W0, FSBC_W1} && st_next == FSBC_FIN)
        begin
            case (op_reg)
                FSBC_OP_ESUSPEND:
                begin
                    esusp_reg <= 1'b1;
                    esect_reg <= adr_reg;
                end
                FSBC_OP_ERESUME:  esusp_reg <= 1'b0;
                FSBC_OP_PSUSPEND: psusp_reg <= 1'b1;
                FSBC_OP_PRESUME:  psusp_reg <= 1'b0;
                FSBC_OP_BYP_ENT:  byp_reg   <= 1'b1;
                FSBC_OP_BYP_EXIT: byp_reg   <= 1'b0;
                FSBC_OP_RESET3:
                begin
                    byp_reg   <= acc_reg;
                    psusp_reg <= 1'b0;
                    esusp_reg <= 1'b0;
                end
                FSBC_OP_ACC_ON:
                begin
                    acc_reg <= 1'b1;
                    byp_reg <= 1'b1;
                end
                FSBC_OP_ACC_OFF:
                begin
                    acc_reg <= 1'b0;
                    byp_reg <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // per-sector accelerated use counters
    generate
        for (genvar g = 0; g < 2**SECT_W; g++)
        begin : g_acc
            always_ff @(posedge CLOCK)
            begin
                if (!RST_N)
                    acc_use[g] <= 4'h0;
                else if (st_reg == FSBC_IDLE && REQ && legal &&
                         OP == FSBC_OP_ACC_ON && sect == SECT_W'(g))
                    acc_use[g] <= acc_use[g] + 4'h1;
            end
        end
    endgenerate

    assign ACK         = (st_reg == FSBC_FIN);
    assign BYPASS      = byp_reg;
    assign PSUSP       = psusp_reg;
    assign ESUSP       = esusp_reg;
    assign ACCEL_HV_EN = acc_reg;

    // accel enable only rises while idle of suspends
    property p_acc_rise;
        @(posedge CLOCK) disable iff (!RST_N)
        $rose(acc_reg) |-> !$past(psusp_reg) && !$past(esusp_reg);
    endproperty
    a_acc_rise: assert property (p_acc_rise)
        else $error("accel raised during suspend");
    // bypass program write one carries setup data
    property p_bprog;
        @(posedge CLOCK) disable iff (!RST_N)
        w_start && op_reg == FSBC_OP_BYP_PROG && idx_reg == 2'd0
            |-> w_data == D_PROG_SETUP;
    endproperty
    a_bprog: assert property (p_bprog)
        else $error("bypass program setup word wrong");
    // entry second write goes to the 2aa offset
    property p_entry;
        @(posedge CLOCK) disable iff (!RST_N)
        w_start && op_reg == FSBC_OP_BYP_ENT && idx_reg == 2'd1
            |-> w_addr[11:0] == A_UNLOCK2 && w_data == D_UNLOCK2;
    endproperty
    a_entry: assert property (p_entry)
        else $error("bypass entry unlock two wrong");
    // exit ends bypass once acknowledged
    property p_exit;
        @(posedge CLOCK) disable iff (!RST_N)
        $rose(ACK) && op_reg == FSBC_OP_BYP_EXIT && !ERR |=> !byp_reg;
    endproperty
    a_exit: assert property (p_exit)
        else $error("bypass still set after exit");
    // accel uses never pass the limit
    property p_uses;
        @(posedge CLOCK) disable iff (!RST_N)
        $rose(acc_reg) |-> acc_use[sect_of(adr_reg)] <= ACCEL_MAX_USES;
    endproperty
    a_uses: assert property (p_uses)
        else $error("accel use count exceeded");
    // a refused request answers with error and leaves bypass and both suspend flags alone
    property p_refuse;
        @(posedge CLOCK) disable iff (!RST_N)
        st_reg == FSBC_IDLE && REQ && !legal |=> ERR && ACK &&
            $stable(byp_reg) && $stable(psusp_reg) && $stable(esusp_reg);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused request changed a mode");
endmodule : fsbc_host

// File: dv/fsbc_flash_model.sv
// Purpose: behavioural flash device facing the host sequencer
// Assumes: commands latched on the rising edge of the write strobe
// Notes:   logs every write; busy runs a fixed time after a program
`timescale 1ns/1ps
module fsbc_flash_model
    import fsbc_pkg::*;
#(
    parameter int AW      = 24,
    parameter int PROG_NS = 800
)
(
    input  wire logic          we_n,
    input  wire logic [AW-1:0] a,
    input  wire logic [15:0]   dq,
    input  wire logic          hv,
    output logic               busy
);
    logic [AW-1:0] wa[$];   // logged write addresses
    logic [15:0]   wd[$];   // logged write data
    logic          bypass;  // unlock bypass mode
    logic          prog;    // next write is program data
    logic          exit1;   // first exit write seen
    logic [1:0]    u;       // unlock cycles seen
    int            bad;     // writes the device refuses in bypass
    event          prog_ev; // embedded program launch
    initial
    begin
        busy = 1'b0;
        bypass = 1'b0;
        prog = 1'b0;
        exit1 = 1'b0;
        u = 2'd0;
        bad = 0;
    end
    // high voltage on the accel pin forces bypass, removal ends it
    always @(posedge hv) bypass = 1'b1;
    always @(negedge hv) bypass = 1'b0;
    // embedded program keeps the device busy for a fixed span
    always
    begin
        @(prog_ev);
        busy = 1'b1;
        #(PROG_NS);
        busy = 1'b0;
    end
    // command decode; suspend and resume ignore the address
    always @(posedge we_n)
    begin
        wa.push_back(a);
        wd.push_back(dq);
        if (prog)
        begin
            prog = 1'b0;
            -> prog_ev;
        end
        else if (exit1)
        begin
            exit1 = 1'b0;
            if (dq === D_BYPASS_EXIT2) bypass = 1'b0;
        end
        else if (dq === D_UNLOCK1 && a[11:0] === A_UNLOCK1) u = 2'd1;
        else if (dq === D_UNLOCK2 && a[11:0] === A_UNLOCK2 && u == 2'd1)
            u = 2'd2;
        else if (u == 2'd2 && dq === D_BYPASS_ENTER)
        begin
            bypass = 1'b1;
            u = 2'd0;
        end
        else if (bypass && dq === D_PROG_SETUP) prog = 1'b1;
        else if (bypass && dq === D_BYPASS_EXIT1) exit1 = 1'b1;
        else if (bypass && !(u == 2'd2 && dq === D_RESET)) bad++;
        else u = 2'd0;
    end
endmodule : fsbc_flash_model

// File: dv/fsbc_host_tb.sv
// Purpose: self-checking bench for the suspend and bypass sequencer
// Assumes: device model logs every bus write
// Notes:   writes are judged from the log, counted back from the end
`timescale 1ns/1ps
module fsbc_host_tb
    import fsbc_pkg::*;
;
    logic        CLOCK, RST_N, REQ;            // clock, reset, request
    logic [3:0]  OP;                           // request opcode
    logic [23:0] ADDR, FLASH_A;                // request and bus address
    logic [15:0] WDATA, FLASH_DQ_O;            // program and bus data
    logic        ACK, ERR, BYPASS, PSUSP, ESUSP; // answers and modes
    logic        FLASH_BUSY_IN, FLASH_DQ_OE;   // device busy, data drive
    logic        FLASH_WE_N, ACCEL_HV_EN;      // strobe, accel voltage
    int          fail_count;                   // mismatches
    int          n_compared;                   // comparisons
    fsbc_host #(.AW(24), .SECT_W(8)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
        .REQ(REQ), .OP(OP), .ADDR(ADDR), .WDATA(WDATA), .ACK(ACK),
        .ERR(ERR), .BYPASS(BYPASS), .PSUSP(PSUSP), .ESUSP(ESUSP),
        .FLASH_BUSY_IN(FLASH_BUSY_IN), .FLASH_A(FLASH_A),
        .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE(FLASH_DQ_OE),
        .FLASH_WE_N(FLASH_WE_N), .ACCEL_HV_EN(ACCEL_HV_EN));
    fsbc_flash_model #(.AW(24)) flash (.we_n(FLASH_WE_N), .a(FLASH_A),
        .dq(FLASH_DQ_O), .hv(ACCEL_HV_EN), .busy(FLASH_BUSY_IN));
    // 125 MHz clock
    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    // data must still be driven when the strobe rises
    always @(posedge FLASH_WE_N)
        if (RST_N === 1'b1) chk_b(FLASH_DQ_OE, 1'b1);
    task automatic chk_b(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_b
    task automatic chk_w(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w
    // one request held until answered; checks refusal and write count
    task automatic op(input fsbc_op_t o, input logic [23:0] a,
                      input logic [15:0] d, input logic e, input int n);
        int k;
        int base;
        base = flash.wa.size();
        k = 0;
        REQ = 1'b1;
        OP = o;
        ADDR = a;
        WDATA = d;
        while (ACK !== 1'b1 && k < 400)
        begin
            @(posedge CLOCK);
            #1;
            k++;
        end
        chk_b(ACK, 1'b1);
        chk_b(ERR, e);
        chk_w(24'(flash.wa.size() - base), 24'(n));
        REQ = 1'b0;
        @(posedge CLOCK);
        #1;
    endtask : op
    // logged write counted back from the newest; address optional
    task automatic wr(input int back, input logic [23:0] a,
                      input logic [15:0] d, input logic ca);
        int i;
        i = flash.wa.size() - back;
        chk_w({8'h0, flash.wd[i]}, {8'h0, d});
        if (ca)
            chk_w(flash.wa[i], a);
    endtask : wr
    // wait out the device program plus the pin synchroniser
    task automatic idle_wait();
        int k;
        k = 0;
        while (FLASH_BUSY_IN !== 1'b0 && k < 1000)
        begin
            @(posedge CLOCK);
            k++;
        end
        repeat (6) @(posedge CLOCK);
        #1;
    endtask : idle_wait
    task automatic s_susp();
        op(FSBC_OP_ESUSPEND, 24'h450000, 16'h0, 1'b0, 1);
        wr(1, 24'h0, D_SUSPEND, 1'b0);
        chk_b(ESUSP, 1'b1);
        op(FSBC_OP_PSUSPEND, 24'h123abc, 16'h0, 1'b0, 1);
        wr(1, 24'h0, D_SUSPEND, 1'b0);
        chk_b(PSUSP, 1'b1);
        op(FSBC_OP_ERESUME, 24'h450000, 16'h0, 1'b1, 0);
        op(FSBC_OP_PRESUME, 24'h9a0001, 16'h0, 1'b0, 1);
        wr(1, 24'h0, D_RESUME, 1'b0);
        chk_b(PSUSP, 1'b0);
        op(FSBC_OP_PRESUME, 24'h9a0001, 16'h0, 1'b1, 0);
        op(FSBC_OP_PSUSPEND, 24'h000000, 16'h0, 1'b0, 1);
        op(FSBC_OP_PRESUME, 24'hffffff, 16'h0, 1'b0, 1);
        op(FSBC_OP_ERESUME, 24'h460000, 16'h0, 1'b1, 0);
        op(FSBC_OP_ERESUME, 24'h4500f0, 16'h0, 1'b0, 1);
        wr(1, 24'h4500f0, D_RESUME, 1'b1);
        chk_b(ESUSP, 1'b0);
    endtask : s_susp
    task automatic s_bypass();
        op(FSBC_OP_BYP_ENT, 24'h123456, 16'h0, 1'b0, 3);
        wr(3, 24'h123555, D_UNLOCK1, 1'b1);
        wr(2, 24'h1232aa, D_UNLOCK2, 1'b1);
        wr(1, 24'h123555, D_BYPASS_ENTER, 1'b1);
        chk_b(BYPASS, 1'b1);
        op(FSBC_OP_BYP_PROG, 24'h234567, 16'hbeef, 1'b0, 2);
        wr(2, 24'h234567, D_PROG_SETUP, 1'b1);
        wr(1, 24'h234567, 16'hbeef, 1'b1);
        op(FSBC_OP_ESUSPEND, 24'h0, 16'h0, 1'b1, 0);
        op(FSBC_OP_PSUSPEND, 24'h0, 16'h0, 1'b1, 0);
        op(FSBC_OP_BYP_ENT, 24'h0, 16'h0, 1'b1, 0);
        op(FSBC_OP_BYP_EXIT, 24'h345678, 16'h0, 1'b0, 2);
        wr(2, 24'h345678, D_BYPASS_EXIT1, 1'b1);
        wr(1, 24'h0, D_BYPASS_EXIT2, 1'b0);
        chk_b(BYPASS, 1'b0);
        op(FSBC_OP_BYP_PROG, 24'h234567, 16'h1234, 1'b1, 0);
    endtask : s_bypass
    task automatic s_reset3();
        op(FSBC_OP_RESET3, 24'h5a1234, 16'h0, 1'b0, 3);
        wr(3, 24'h5a1555, D_UNLOCK1, 1'b1);
        wr(2, 24'h5a12aa, D_UNLOCK2, 1'b1);
        wr(1, 24'h5a1555, D_RESET, 1'b1);
    endtask : s_reset3
    task automatic s_acc_limit();
        idle_wait();
        for (int i = 0; i < 10; i++)
        begin
            op(FSBC_OP_ACC_ON, 24'h770000, 16'h0, 1'b0, 0);
            chk_b(ACCEL_HV_EN, 1'b1);
            op(FSBC_OP_ACC_OFF, 24'h770000, 16'h0, 1'b0, 0);
            chk_b(ACCEL_HV_EN, 1'b0);
        end
        op(FSBC_OP_ACC_ON, 24'h77ffff, 16'h0, 1'b1, 0);
        chk_b(ACCEL_HV_EN, 1'b0);
    endtask : s_acc_limit
    task automatic s_accel_busy();
        op(FSBC_OP_ACC_ON, 24'h660000, 16'h0, 1'b0, 0);
        chk_b(BYPASS, 1'b1);
        op(FSBC_OP_BYP_PROG, 24'h661234, 16'h5a5a, 1'b0, 2);
        op(FSBC_OP_BYP_EXIT, 24'h660000, 16'h0, 1'b1, 0);
        op(FSBC_OP_ACC_OFF, 24'h660000, 16'h0, 1'b1, 0);
        chk_b(ACCEL_HV_EN, 1'b1);
        idle_wait();
        op(FSBC_OP_ACC_OFF, 24'h660000, 16'h0, 1'b0, 0);
        chk_b(ACCEL_HV_EN, 1'b0);
        chk_b(BYPASS, 1'b0);
    endtask : s_accel_busy
    task automatic test_done();
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // watchdog well beyond the expected run
    initial
    begin
        #200000;
        fail_count++;
        test_done();
    end
    // main sequence
    initial
    begin
        fail_count = 0;
        n_compared = 0;
        RST_N = 1'b0;
        REQ = 1'b0;
        OP = 4'h0;
        ADDR = 24'h0;
        WDATA = 16'h0;
        repeat (3) @(posedge CLOCK);
        #1;
        RST_N = 1'b1;
        chk_b(FLASH_WE_N, 1'b1);
        s_susp();
        s_bypass();
        s_reset3();
        s_acc_limit();
        s_accel_busy();
        chk_w(24'(flash.bad), 24'h0);
        test_done();
    end
endmodule : fsbc_host_tb
